// ==== core/sov_defines.svh ====
// Purpose: Offsets, reset values, field spans and counts for the sync regenerator
// Assumes: Word-aligned registers, byte address = index * 4
// Notes:   Definitions only
`ifndef SOV_DEFINES_SVH
`define SOV_DEFINES_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define SOV_IDX_MODE   8'hD6
`define SOV_IDX_WIDTH  8'hD7
`define SOV_IDX_POLPOS 8'hD8
`define SOV_IDX_HFPH   8'hD9
`define SOV_IDX_LOW    8'hDA
`define SOV_IDX_VFPH   8'hDB
`define SOV_IDX_STAT   8'hDC

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SOV_RST_MODE   8'hC0
`define SOV_RST_WIDTH  8'h43
`define SOV_RST_POLPOS 8'h00
`define SOV_RST_HFPH   8'h4A
`define SOV_RST_LOW    8'h18
`define SOV_RST_VFPH   8'h32

// ----------------------------------------
// Fields and address spans
// ----------------------------------------
`define SOV_LOW_VTOL   7:6
`define SOV_LOW_VFP    5:2
`define SOV_LOW_HFP    1:0
`define SOV_ADDR_IDX   9:2
`define SOV_ADDR_HI    31:10
`define SOV_HSIZE_WORD 3'h2

// ----------------------------------------
// Output modes
// ----------------------------------------
`define SOV_M_FREE     2'h0
`define SOV_M_SNAP     2'h1
`define SOV_M_ALIGN    2'h2
`define SOV_M_COPY     2'h3

// ----------------------------------------
// Counts
// ----------------------------------------
`define SOV_H_MISS_PAD 2
`define SOV_SERR_SUB   8
`define SOV_SDLY_DEPTH 3

`endif

// ==== core/sov_pkg.sv ====
// Purpose: Register field layouts of the sync regenerator
// Assumes: Fields packed msb first as in the register map
// Notes:   Types only
package sov_pkg;

    typedef struct packed {
        logic       v_output_enable;
        logic       h_output_enable;
        logic [1:0] v_output_mode;
        logic [1:0] h_output_mode;
        logic [1:0] h_tol;
    } sov_mode_ctrl_t;

    typedef struct packed {
        logic       field_flag_enable;
        logic [3:0] vpw;
        logic [2:0] hpw;
    } sov_width_t;

    typedef struct packed {
        logic [1:0] scaler_sync_delay;
        logic       shift_lead;
        logic [2:0] shift;
        logic       v_output_polarity;
        logic       h_output_polarity;
    } sov_polpos_t;

endpackage

// ==== core/sov_sync2.sv ====
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to clk
// Notes:   First stage feeds only the second
`timescale 1ns/1ps

module sov_sync2 #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end

    assign q = s2_q;
endmodule

// ==== core/sov_line_delay.sv ====
// Purpose: Scaler vertical sync with rising edge delayed by whole lines
// Assumes: tick marks each horizontal output leading edge
// Notes:   Falling edge follows the source on the next clock
`timescale 1ns/1ps

module sov_line_delay #(
    parameter int DEPTH = 3
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     tick,
    input  wire logic                     d,
    input  wire logic [$clog2(DEPTH+1)-1:0] sel,
    output logic                          q
);
    logic [DEPTH-1:0] taps_q;
    logic             q_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            taps_q <= '0;
        end else if (tick) begin
            taps_q <= {taps_q[DEPTH-2:0], d};
        end
    end

    // Gate by delayed copy: late rise, prompt fall
    always_ff @(posedge clk) begin
        if (rst) begin
            q_q <= 1'b0;
        end else if (sel == '0) begin
            q_q <= d;
        end else begin
            q_q <= d & taps_q[sel - 1'b1];
        end
    end

    assign q = q_q;
endmodule

// ==== core/sov_sync_regen.sv ====
// Purpose: Regenerates horizontal and vertical sync outputs and scaler sync
// Assumes: Positive-going sync inputs; AHB-Lite single word accesses
// Notes:   Horizontal counts in clk cycles, vertical counts in output lines
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "sov_defines.svh"

module sov_sync_regen #(
    parameter int HW = 12,
    parameter int VW = 12
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        h_sync_in,
    input  wire logic        v_sync_in,
    output logic             h_pulse_output,
    output logic             v_pulse_output,
    output logic             scaler_vertical_sync
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // width table
    function automatic logic [5:0] hpw_cnt(input logic [2:0] c);
        case (c)
            3'h0:    hpw_cnt = 6'h04;
            3'h1:    hpw_cnt = 6'h08;
            3'h2:    hpw_cnt = 6'h10;
            3'h3:    hpw_cnt = 6'h14;
            3'h4:    hpw_cnt = 6'h18;
            3'h5:    hpw_cnt = 6'h1C;
            3'h6:    hpw_cnt = 6'h20;
            default: hpw_cnt = 6'h24;
        endcase
    endfunction

    function automatic logic [7:0] tol_cnt(input logic [1:0] c, input logic vert);
        case (c)
            2'h0:    tol_cnt = 8'h04;
            2'h1:    tol_cnt = 8'h08;
            2'h2:    tol_cnt = 8'h10;
            default: tol_cnt = vert ? 8'h58 : 8'h10;
        endcase
    endfunction

    function automatic logic [15:0] absd(input logic [15:0] a, input logic [15:0] b);
        absd = (a > b) ? a - b : b - a;
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    sov_pkg::sov_mode_ctrl_t mode_q;
    sov_pkg::sov_width_t     width_q;
    sov_pkg::sov_polpos_t    polpos_q;
    logic [7:0]    hfph_q;
    logic [7:0]    low_q;
    logic [7:0]    vfph_q;
    logic          wr_q;
    logic [7:0]    widx_q;
    logic [31:0]   hrdata_q;
    logic          hreadyout_q;
    logic          hresp_q;
    logic [11:0]   cfg_quiet_q;
    logic          acc;
    logic          hit;
    logic [9:0]    hfp;
    logic [11:0]   vfp;
    logic [1:0]    sy;
    logic          hs;
    logic          vs;
    logic          hs_d_q;
    logic          vs_d_q;
    logic          h_rise;
    logic          v_rise;
    logic [HW-1:0] hin_q;
    logic [HW-1:0] href_q;
    logic [HW-1:0] hgen_q;
    logic [HW-1:0] h_thr;
    logic [7:0]    htl;
    logic [5:0]    hpw;
    logic [5:0]    h_left_q;
    logic [5:0]    h_left_d;
    logic          h_miss01;
    logic          h_miss10;
    logic          h_acc10;
    logic          h_lead;
    logic          h_raw_d;
    logic          h_raw_q;
    logic          h_tick;
    logic [VW-1:0] vin_q;
    logic [VW-1:0] vref_q;
    logic [VW-1:0] vgen_q;
    logic [VW-1:0] vin_nx;
    logic [VW-1:0] v_tgt;
    logic [7:0]    vtl;
    logic [5:0]    vpw_l;
    logic [5:0]    v_left_q;
    logic [5:0]    v_left_d;
    logic          v_pend_q;
    logic          v_miss;
    logic          v_lead;
    logic          vsamp_q;
    logic          vsamp_d;
    logic          v_raw_d;
    logic          v_raw_q;
    logic          field_q;
    logic          h_out_q;
    logic          v_out_q;
    logic [HW-1:0] hper_q;

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    assign acc = hsel && hready && htrans[1];
    assign hit = (haddr[`SOV_ADDR_HI] == '0) && (hsize == `SOV_HSIZE_WORD);

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q        <= 1'b0;
            widx_q      <= '0;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end else begin
            wr_q        <= acc && hwrite && hit;
            widx_q      <= haddr[`SOV_ADDR_IDX];
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end
    end

    // Read word captured in the address phase
    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata_q <= '0;
        end else if (acc && !hwrite) begin
            hrdata_q <= '0;
            if (hit) begin
                case (haddr[`SOV_ADDR_IDX])
                    `SOV_IDX_MODE:   hrdata_q[7:0] <= mode_q;
                    `SOV_IDX_WIDTH:  hrdata_q[7:0] <= width_q;
                    `SOV_IDX_POLPOS: hrdata_q[7:0] <= polpos_q;
                    `SOV_IDX_HFPH:   hrdata_q[7:0] <= hfph_q;
                    `SOV_IDX_LOW:    hrdata_q[7:0] <= low_q;
                    `SOV_IDX_VFPH:   hrdata_q[7:0] <= vfph_q;
                    `SOV_IDX_STAT:   hrdata_q <= {4'h0, 12'(vref_q), 12'(href_q),
                                                  1'b0, field_q, v_raw_q, h_raw_q};
                    default:         hrdata_q <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q   <= `SOV_RST_MODE;
            width_q  <= `SOV_RST_WIDTH;
            polpos_q <= `SOV_RST_POLPOS;
            hfph_q   <= `SOV_RST_HFPH;
            low_q    <= `SOV_RST_LOW;
            vfph_q   <= `SOV_RST_VFPH;
        end else if (wr_q) begin
            case (widx_q)
                `SOV_IDX_MODE:   mode_q   <= hwdata[7:0];
                `SOV_IDX_WIDTH:  width_q  <= hwdata[7:0];
                `SOV_IDX_POLPOS: polpos_q <= hwdata[7:0];
                `SOV_IDX_HFPH:   hfph_q   <= hwdata[7:0];
                `SOV_IDX_LOW:    low_q    <= hwdata[7:0];
                `SOV_IDX_VFPH:   vfph_q   <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst || wr_q) begin
            cfg_quiet_q <= '0;
        end else if (cfg_quiet_q != '1) begin
            cfg_quiet_q <= cfg_quiet_q + 12'h001;
        end
    end

    assign hfp = {hfph_q, low_q[`SOV_LOW_HFP]};
    assign vfp = {vfph_q, low_q[`SOV_LOW_VFP]};

    // ----------------------------------------
    // Input capture and horizontal measurement
    // ----------------------------------------
    sov_sync2 #(.W(2)) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({v_sync_in, h_sync_in}),
        .q   (sy)
    );
    assign hs     = sy[0];
    assign vs     = sy[1];
    assign h_rise = hs && !hs_d_q;
    assign v_rise = vs && !vs_d_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            hs_d_q <= 1'b0;
            vs_d_q <= 1'b0;
        end else begin
            hs_d_q <= hs;
            vs_d_q <= vs;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hin_q  <= '0;
            href_q <= '0;
        end else if (h_rise) begin
            hin_q <= '0;
            if (absd(16'(hin_q + 1'b1), 16'(href_q)) > 16'(htl)) begin
                href_q <= HW'(hin_q + 1'b1);
            end
        end else if (hin_q != '1) begin
            hin_q <= hin_q + 1'b1;
        end
    end

    // ----------------------------------------
    // Horizontal output generation
    // ----------------------------------------
    always_comb begin
        hpw      = hpw_cnt(width_q.hpw);
        htl      = tol_cnt(mode_q.h_tol, 1'b0);
        h_thr    = ((href_q >> 3) > HW'(`SOV_SERR_SUB)) ?
                   HW'((href_q >> 3) - HW'(`SOV_SERR_SUB)) : '0;
        h_miss01 = hgen_q >= HW'(href_q + (href_q >> 2) + HW'(`SOV_H_MISS_PAD));
        h_miss10 = hgen_q >= HW'(href_q + HW'(htl));
        h_acc10  = h_rise && (hgen_q >= HW'(href_q - h_thr));
        case (mode_q.h_output_mode)
            `SOV_M_FREE:  h_lead = HW'(hgen_q + 1'b1) >= HW'(hfp);
            `SOV_M_SNAP:  h_lead = h_miss01 && !h_rise;
            `SOV_M_ALIGN: h_lead = h_acc10 || h_miss10;
            default:      h_lead = 1'b0;
        endcase
        if (h_lead) begin
            h_left_d = hpw;
        end else if (h_left_q != '0) begin
            h_left_d = h_left_q - 6'h01;
        end else begin
            h_left_d = '0;
        end
        case (mode_q.h_output_mode)
            `SOV_M_SNAP: h_raw_d = hs || (h_left_d != '0);
            `SOV_M_COPY: h_raw_d = hs;
            default:     h_raw_d = h_left_d != '0;
        endcase
    end

    assign h_tick = h_raw_d && !h_raw_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            hgen_q   <= '0;
            h_left_q <= '0;
            h_raw_q  <= 1'b0;
        end else begin
            h_left_q <= h_left_d;
            h_raw_q  <= h_raw_d;
            if (h_lead || (mode_q.h_output_mode == `SOV_M_SNAP && h_rise)) begin
                hgen_q <= '0;
            end else if (hgen_q != '1) begin
                hgen_q <= hgen_q + 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Vertical measurement and generation
    // ----------------------------------------
    always_comb begin
        vtl     = tol_cnt(low_q[`SOV_LOW_VTOL], 1'b1);
        vpw_l   = 6'({width_q.vpw, 1'b0}) + 6'h02;
        v_miss  = (vref_q != '0) && (VW'(vin_q + 1'b1) > VW'(vref_q + VW'(vtl)));
        vin_nx  = (v_pend_q || v_miss) ? '0 : VW'(vin_q + 1'b1);
        v_tgt   = polpos_q.shift_lead ? VW'(vref_q - VW'(polpos_q.shift) - 1'b1)
                                      : VW'(polpos_q.shift);
        vsamp_d = h_tick ? vs : vsamp_q;
        case (mode_q.v_output_mode)
            `SOV_M_FREE:  v_lead = h_tick && (VW'(vgen_q + 1'b1) >= VW'(vfp));
            `SOV_M_SNAP:  v_lead = h_tick && v_miss && !v_pend_q;
            // shifted start, also after a missing pulse
            `SOV_M_ALIGN: v_lead = h_tick && (vin_nx == v_tgt);
            default:      v_lead = 1'b0;
        endcase
        if (v_lead) begin
            v_left_d = vpw_l;
        end else if (h_tick && v_left_q != '0) begin
            v_left_d = v_left_q - 6'h01;
        end else begin
            v_left_d = v_left_q;
        end
        case (mode_q.v_output_mode)
            `SOV_M_SNAP: v_raw_d = vsamp_d || (v_left_d != '0);
            `SOV_M_COPY: v_raw_d = vs;
            default:     v_raw_d = v_left_d != '0;
        endcase
    end

    // Edge held until next line start; new edge wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            v_pend_q <= 1'b0;
        end else begin
            v_pend_q <= v_rise || (v_pend_q && !h_tick);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            vin_q  <= '0;
            vref_q <= '0;
        end else if (h_tick) begin
            vin_q <= vin_nx;
            if (v_pend_q && absd(16'(vin_q + 1'b1), 16'(vref_q)) > 16'(vtl)) begin
                vref_q <= VW'(vin_q + 1'b1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            vgen_q   <= '0;
            v_left_q <= '0;
            vsamp_q  <= 1'b0;
            v_raw_q  <= 1'b0;
        end else begin
            v_left_q <= v_left_d;
            vsamp_q  <= vsamp_d;
            v_raw_q  <= v_raw_d;
            if (h_tick) begin
                vgen_q <= v_lead ? '0 : VW'(vgen_q + 1'b1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !width_q.field_flag_enable) begin
            field_q <= 1'b0;
        end else if (v_rise) begin
            field_q <= hin_q >= (href_q >> 1);
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // enable gate and polarity
    always_ff @(posedge clk) begin
        if (rst) begin
            h_out_q <= 1'b0;
            v_out_q <= 1'b0;
        end else begin
            h_out_q <= mode_q.h_output_enable && (h_raw_d ^ polpos_q.h_output_polarity);
            v_out_q <= mode_q.v_output_enable && (v_raw_d ^ polpos_q.v_output_polarity);
        end
    end

    sov_line_delay #(.DEPTH(`SOV_SDLY_DEPTH)) u_sdly (
        .clk  (clk),
        .rst  (rst),
        .tick (h_tick),
        .d    (v_raw_q),
        .sel  (polpos_q.scaler_sync_delay),
        .q    (scaler_vertical_sync)
    );

    assign h_pulse_output = h_out_q;
    assign v_pulse_output = v_out_q;
    assign hrdata         = hrdata_q;
    assign hreadyout      = hreadyout_q;
    assign hresp          = hresp_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            hper_q <= '0;
        end else begin
            hper_q <= h_tick ? HW'(1) : ((hper_q != '1) ? HW'(hper_q + 1'b1) : hper_q);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_h_disabled_low: assert property (
        !mode_q.h_output_enable |=> !h_pulse_output) else $error("h output not low");
    chk_v_disabled_low: assert property (
        !mode_q.v_output_enable |=> !v_pulse_output) else $error("v output not low");
    chk_h_copy_mode: assert property (
        mode_q.h_output_mode == `SOV_M_COPY |=> h_raw_q == $past(hs))
        else $error("h copy mismatch");
    chk_v_copy_mode: assert property (
        mode_q.v_output_mode == `SOV_M_COPY |=> v_raw_q == $past(vs))
        else $error("v copy mismatch");
    chk_v_out_polarity: assert property (
        mode_q.v_output_enable && mode_q.v_output_mode == `SOV_M_COPY && !wr_q
        |=> v_pulse_output == ($past(vs) ^ polpos_q.v_output_polarity))
        else $error("v polarity wrong");
    chk_h_free_period: assert property (
        h_tick && mode_q.h_output_mode == `SOV_M_FREE && cfg_quiet_q == '1
        && 16'(hfp) > 16'(hpw) |-> hper_q == HW'(hfp)) else $error("h period wrong");
    chk_scaler_fall: assert property (
        !v_raw_q |=> !scaler_vertical_sync) else $error("scaler sync late fall");
    chk_h_tol_hold: assert property (
        h_rise && absd(16'(hin_q + 1'b1), 16'(href_q)) <= 16'(htl) |=> $stable(href_q))
        else $error("h reference moved");
    chk_field_gate: assert property (
        !width_q.field_flag_enable |=> !field_q) else $error("field flag set");
    chk_h_insert: assert property (
        mode_q.h_output_mode == `SOV_M_SNAP && h_miss01 && !wr_q |=> h_raw_q)
        else $error("h pulse not inserted");

    cov_v_shift: cover property (mode_q.v_output_mode == `SOV_M_ALIGN && v_lead);
    cov_h_insert: cover property (mode_q.h_output_mode == `SOV_M_SNAP && h_lead);
    cov_scaler_dly: cover property (polpos_q.scaler_sync_delay == 2'h3
        && $rose(scaler_vertical_sync));

endmodule

// ==== tb/sov_sync_src.sv ====
// Purpose: Incoming video sync source feeding the regenerator
// Assumes: Positive pulses, h_sync timed from the pixel counter, v_sync from the line counter
// Notes:   Both lines stay low while disabled
`timescale 1ns/1ps

module sov_sync_src #(
    parameter int HPER   = 80,
    parameter int HWID   = 6,
    parameter int VLINES = 20,
    parameter int VWID   = 3
) (
    input  wire logic clk,
    input  wire logic en,
    output logic      h_sync,
    output logic      v_sync
);
    int hc;
    int lc;

    // ----------------------------------------
    // Line and frame timing
    // ----------------------------------------
    always @(posedge clk) begin
        if (!en) begin
            hc     <= 0;
            lc     <= 0;
            h_sync <= 1'b0;
            v_sync <= 1'b0;
        end else begin
            hc     <= (hc == HPER - 1) ? 0 : hc + 1;
            if (hc == HPER - 1) begin
                lc <= (lc == VLINES - 1) ? 0 : lc + 1;
            end
            h_sync <= (hc < HWID);
            v_sync <= (lc < VWID);
        end
    end
endmodule

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the sync regenerator
// Assumes: Zero-wait AHB-Lite slave, 20 MHz clock
// Notes:   Waveforms judged by pulse width and period in clocks
`timescale 1ns/1ps
`include "sov_defines.svh"

module tb;
    logic        clk    = 1'b0;
    logic        rst    = 1'b1;
    logic        hsel   = 1'b0;
    logic [31:0] haddr  = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize  = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        src_en = 1'b0;
    logic [31:0] hrdata;
    logic        hrsp;
    logic [31:0] rd;
    logic        hrdy;
    logic        h_in;
    logic        v_in;
    logic [2:0]  mon;
    int          n_fail     = 0;
    int          n_compared = 0;
    int          hi;
    int          per;
    int          wtab [8]   = '{4, 8, 16, 20, 24, 28, 32, 36};

    always #25 clk = ~clk;

    sov_sync_regen i_dut (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
        .hrdata(hrdata), .hreadyout(hrdy), .hresp(hrsp),
        .h_sync_in(h_in), .v_sync_in(v_in), .h_pulse_output(mon[0]),
        .v_pulse_output(mon[1]), .scaler_vertical_sync(mon[2])
    );

    sov_sync_src i_src (.clk(clk), .en(src_en), .h_sync(h_in), .v_sync(v_in));

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic complete_run();
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: register %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int exp, input int tol);
        n_compared++;
        if (got < exp - tol || got > exp + tol) begin
            n_fail++;
            $display("wrong value at %0t: count %0d, expected %0d", $time, got, exp);
        end
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hrdy !== 1'b1 && n < 16);
        if (hrdy !== 1'b1) begin
            n_fail++;
            complete_run();
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        haddr  <= {22'h00_0000, idx, 2'h0};
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, wd};
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic span(input int s, input logic lvl, output int c);
        c = 0;
        while (mon[s] === lvl && c < 9000) begin
            @(negedge clk);
            c++;
        end
        if (c >= 9000) begin
            n_fail++;
            complete_run();
        end
    endtask

    task automatic meas(input int s);
        int c;
        span(s, 1'b1, c);
        span(s, 1'b0, c);
        span(s, 1'b1, hi);
        span(s, 1'b0, per);
        per += hi;
    endtask

    task automatic wave(input int s, input int ehi, input int eper);
        meas(s);
        meas(s);
        @(posedge clk);
        chk_n(hi, ehi, 2);
        chk_n(per, eper, 2);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int         c;
        logic [7:0] rv [6];
        rv = '{`SOV_RST_MODE, `SOV_RST_WIDTH, `SOV_RST_POLPOS,
               `SOV_RST_HFPH, `SOV_RST_LOW, `SOV_RST_VFPH};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            ahb(1'b0, 8'hD6 + i[7:0], 8'h00);
            chk(rd, {24'h00_0000, rv[i]});
        end
        ahb(1'b1, `SOV_IDX_HFPH, 8'h10);
        ahb(1'b1, `SOV_IDX_LOW, 8'h0C);
        ahb(1'b1, `SOV_IDX_VFPH, 8'h02);
        ahb(1'b1, 8'hD0, 8'h5A);
        ahb(1'b0, `SOV_IDX_LOW, 8'h00);
        chk(rd, 32'h0000_000C);
        chk({31'h0000_0000, hrsp}, 32'h0000_0000);
        ahb(1'b0, 8'hD0, 8'h00);
        chk(rd, 32'h0000_0000);
        for (int w = 0; w < 8; w++) begin
            ahb(1'b1, `SOV_IDX_WIDTH, w[7:0]);
            wave(0, wtab[w], 64);
        end
        ahb(1'b1, `SOV_IDX_POLPOS, 8'h01);
        wave(0, 64 - 36, 64);
        ahb(1'b1, `SOV_IDX_WIDTH, 8'h00);
        wave(1, 2 * 64, 35 * 64);
        ahb(1'b1, `SOV_IDX_WIDTH, 8'h78);
        wave(1, 32 * 64, 35 * 64);
        ahb(1'b1, `SOV_IDX_POLPOS, 8'h02);
        wave(1, 35 * 64 - 32 * 64, 35 * 64);
        ahb(1'b1, `SOV_IDX_WIDTH, 8'h18);
        for (int d = 0; d < 4; d++) begin
            ahb(1'b1, `SOV_IDX_POLPOS, {d[1:0], 6'h00});
            wave(2, (8 - d) * 64, 35 * 64);
        end
        ahb(1'b1, `SOV_IDX_MODE, 8'h00);
        repeat (2) @(posedge clk);
        c = 0;
        repeat (2400) begin
            @(negedge clk);
            c += (mon[1:0] !== 2'b00);
        end
        @(posedge clk);
        chk_n(c, 0, 0);
        src_en <= 1'b1;
        ahb(1'b1, `SOV_IDX_WIDTH, 8'h00);
        ahb(1'b1, `SOV_IDX_POLPOS, 8'h20);
        for (int m = 1; m < 4; m++) begin
            ahb(1'b1, `SOV_IDX_MODE, {4'hF, m[1:0], 2'h0});
            wave(0, (m == 2) ? 4 : 6, 80);
        end
        wave(1, 3 * 80, 20 * 80);
        ahb(1'b1, `SOV_IDX_MODE, 8'hDC);
        wave(1, 3 * 80, 20 * 80);
        ahb(1'b1, `SOV_IDX_MODE, 8'hEC);
        wave(1, 2 * 80, 20 * 80);
        src_en <= 1'b0;
        ahb(1'b1, `SOV_IDX_MODE, 8'hF4);
        wave(0, 4, 80 + 80 / 4 + `SOV_H_MISS_PAD);
        ahb(1'b1, `SOV_IDX_MODE, 8'hF8);
        wave(0, 4, 80 + 4);
        ahb(1'b1, `SOV_IDX_MODE, 8'hFB);
        wave(0, 4, 80 + 16);
        complete_run();
    end
endmodule
